// ---- core/btvc_debounce.v ----
// synchroniser and debounce filter for one key input
`timescale 1ns/10ps
`include "btvc_consts.vh"
module btvc_debounce #(
    parameter CNT_MAX = `BTVC_DEBOUNCE_CYC
) (
    input wire clk_i,
    input wire rstn_i,
    input wire pin_i,
    output reg level_o
);
    reg sync1_q;
    reg sync2_q;
    reg [23:0] cnt_q;

    // pull-up idle: keys rest high
    always @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            sync1_q <= 1'b1;
            sync2_q <= 1'b1;
            cnt_q <= 24'h000000;
            level_o <= 1'b1;
        end
        else
        begin
            sync1_q <= pin_i;
            sync2_q <= sync1_q;
            if (sync2_q == level_o)
                cnt_q <= 24'h000000;
            else if (cnt_q >= CNT_MAX[23:0] - 24'h000001)
            begin
                level_o <= sync2_q;
                cnt_q <= 24'h000000;
            end
            else
                cnt_q <= cnt_q + 24'h000001;
        end
    end
endmodule

// ---- core/btvc_key_trigger.v ----
// key trigger logic for a voice playback module
`timescale 1ns/10ps
`include "btvc_consts.vh"
module btvc_key_trigger #(
    parameter NKEYS = 4,
    parameter DEB_CYC = `BTVC_DEBOUNCE_CYC,
    parameter [7:0] LAST_PIECE = 8'hdb
) (
    input wire CLOCK_I,
    input wire RSTN_I,
    input wire [NKEYS-1:0] KEY_PIN_I,
    input wire [4*NKEYS-1:0] KEY_WAY_I,
    input wire [8*NKEYS-1:0] KEY_PIECE_I,
    input wire ONE_WIRE_MODE_I,
    input wire PLAY_DONE_I,
    output reg SERIAL_LINE_O,
    output reg PLAY_START_O,
    output reg PLAY_STOP_O,
    output reg PLAY_PAUSE_O,
    output reg [7:0] PLAY_PIECE_O,
    output reg VOL_UP_O,
    output reg VOL_DOWN_O,
    output reg BUSY_O
);
    // ------------------------------------------------------------
    // input filtering
    // ------------------------------------------------------------
    wire [NKEYS-1:0] lvl;
    reg [NKEYS-1:0] lvl_q;
    reg line_s1_q;
    reg line_s2_q;
    genvar g;
    generate
        for (g = 0; g < NKEYS; g = g + 1)
        begin : deb
            btvc_debounce #(.CNT_MAX(DEB_CYC)) u_deb (
                .clk_i(CLOCK_I),
                .rstn_i(RSTN_I),
                .pin_i(KEY_PIN_I[g]),
                .level_o(lvl[g])
            );
        end
    endgenerate

    // key four is masked in one-wire mode, its pin carries data
    function key_live;
        input integer k;
        input mode;
        begin
            key_live = !(mode && k == NKEYS - 1);
        end
    endfunction

    // ------------------------------------------------------------
    // playback state
    // ------------------------------------------------------------
    localparam ST_IDLE = 3'b001;
    localparam ST_PLAY = 3'b010;
    localparam ST_PAUSE = 3'b100;

    reg [2:0] st_q;
    reg [2:0] st_d;
    reg [7:0] piece_q;
    reg [7:0] piece_d;
    reg [3:0] owner_q;
    reg [3:0] owner_d;
    reg [NKEYS-1:0] once_done_q;
    reg [NKEYS-1:0] once_done_d;
    reg [NKEYS-1:0] toggle_q;
    reg [NKEYS-1:0] toggle_d;
    reg start_d;
    reg stop_d;
    reg pause_d;
    reg vup_d;
    reg vdn_d;
    reg [3:0] way;
    reg fall;
    reg low;
    reg rise;
    reg playing;
    reg mine;
    integer k;

    always @*
    begin
        st_d = st_q;
        piece_d = piece_q;
        owner_d = owner_q;
        once_done_d = once_done_q;
        toggle_d = toggle_q;
        start_d = 1'b0;
        stop_d = 1'b0;
        pause_d = 1'b0;
        vup_d = 1'b0;
        vdn_d = 1'b0;
        way = 4'h0;
        fall = 1'b0;
        low = 1'b0;
        rise = 1'b0;
        mine = 1'b0;
        playing = (st_q != ST_IDLE);
        // end of a pass: level modes decide whether to go again
        if (st_q == ST_PLAY && PLAY_DONE_I)
        begin
            st_d = ST_IDLE;
            k = owner_q;
            way = KEY_WAY_I[4*k +: 4];
            if (key_live(k, ONE_WIRE_MODE_I) && !lvl[k])
            begin
                if (way == `BTVC_WAY_LVL_LOOP ||
                    way == `BTVC_WAY_LVL_NOMAINT)
                begin
                    st_d = ST_PLAY;
                    start_d = 1'b1;
                end
            end
            if (way == `BTVC_WAY_PLAY_STOP)
                toggle_d[k] = 1'b0;
        end
        // lowest key wins when several act in one cycle
        for (k = NKEYS - 1; k >= 0; k = k - 1)
        begin
            way = KEY_WAY_I[4*k +: 4];
            fall = lvl_q[k] && !lvl[k];
            rise = !lvl_q[k] && lvl[k];
            low = !lvl[k];
            mine = playing && owner_q == k[3:0];
            if (rise)
                once_done_d[k] = 1'b0;
            if (key_live(k, ONE_WIRE_MODE_I))
            begin
                case (way)
                    `BTVC_WAY_EDGE_REP:
                        if (fall)
                        begin
                            st_d = ST_PLAY;
                            start_d = 1'b1;
                            owner_d = k[3:0];
                            piece_d = KEY_PIECE_I[8*k +: 8];
                        end
                    `BTVC_WAY_EDGE_NOREP:
                        if (fall && !playing)
                        begin
                            st_d = ST_PLAY;
                            start_d = 1'b1;
                            owner_d = k[3:0];
                            piece_d = KEY_PIECE_I[8*k +: 8];
                        end
                    `BTVC_WAY_LVL_LOOP, `BTVC_WAY_LVL_ONCE:
                        if (rise && mine)
                        begin
                            st_d = ST_IDLE;
                            stop_d = 1'b1;
                        end
                        else if (low && !once_done_q[k] && fall)
                        begin
                            st_d = ST_PLAY;
                            start_d = 1'b1;
                            owner_d = k[3:0];
                            piece_d = KEY_PIECE_I[8*k +: 8];
                            if (way == `BTVC_WAY_LVL_ONCE)
                                once_done_d[k] = 1'b1;
                        end
                    `BTVC_WAY_LVL_NOMAINT:
                        if (fall && !playing)
                        begin
                            st_d = ST_PLAY;
                            start_d = 1'b1;
                            owner_d = k[3:0];
                            piece_d = KEY_PIECE_I[8*k +: 8];
                        end
                    `BTVC_WAY_PLAY_STOP:
                        if (fall)
                        begin
                            toggle_d[k] = !toggle_q[k];
                            owner_d = k[3:0];
                            if (!toggle_q[k])
                            begin
                                st_d = ST_PLAY;
                                start_d = 1'b1;
                                piece_d = KEY_PIECE_I[8*k +: 8];
                            end
                            else
                            begin
                                st_d = ST_IDLE;
                                stop_d = 1'b1;
                            end
                        end
                    `BTVC_WAY_NEXT_STOP, `BTVC_WAY_NEXT_WRAP:
                        if (fall)
                        begin
                            st_d = ST_PLAY;
                            start_d = 1'b1;
                            owner_d = k[3:0];
                            if (piece_q != LAST_PIECE)
                                piece_d = piece_q + 8'h01;
                            else if (way == `BTVC_WAY_NEXT_WRAP)
                                piece_d = `BTVC_PIECE_RST;
                        end
                    `BTVC_WAY_PREV_STOP, `BTVC_WAY_PREV_WRAP:
                        if (fall)
                        begin
                            st_d = ST_PLAY;
                            start_d = 1'b1;
                            owner_d = k[3:0];
                            if (piece_q != `BTVC_PIECE_RST)
                                piece_d = piece_q - 8'h01;
                            else if (way == `BTVC_WAY_PREV_WRAP)
                                piece_d = LAST_PIECE;
                        end
                    `BTVC_WAY_PAUSE:
                        if (fall && st_q == ST_PLAY)
                        begin
                            st_d = ST_PAUSE;
                            pause_d = 1'b1;
                        end
                        else if (fall && st_q == ST_PAUSE)
                        begin
                            st_d = ST_PLAY;
                            pause_d = 1'b1;
                        end
                    `BTVC_WAY_STOP:
                        if (fall && playing)
                        begin
                            st_d = ST_IDLE;
                            stop_d = 1'b1;
                        end
                    `BTVC_WAY_VOL_UP:
                        vup_d = fall;
                    `BTVC_WAY_VOL_DOWN:
                        vdn_d = fall;
                    default:
                        ;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // registers and outputs
    // ------------------------------------------------------------
    always @(posedge CLOCK_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
        begin
            lvl_q <= {NKEYS{1'b1}};
            st_q <= ST_IDLE;
            piece_q <= `BTVC_PIECE_RST;
            owner_q <= 4'h0;
            once_done_q <= {NKEYS{1'b0}};
            toggle_q <= {NKEYS{1'b0}};
            line_s1_q <= 1'b1;
            line_s2_q <= 1'b1;
            SERIAL_LINE_O <= 1'b1;
            PLAY_START_O <= 1'b0;
            PLAY_STOP_O <= 1'b0;
            PLAY_PAUSE_O <= 1'b0;
            PLAY_PIECE_O <= `BTVC_PIECE_RST;
            VOL_UP_O <= 1'b0;
            VOL_DOWN_O <= 1'b0;
            BUSY_O <= 1'b0;
        end
        else
        begin
            lvl_q <= lvl;
            st_q <= st_d;
            piece_q <= piece_d;
            owner_q <= owner_d;
            once_done_q <= once_done_d;
            toggle_q <= toggle_d;
            // raw synced data; the serial decoder does its own timing
            line_s1_q <= KEY_PIN_I[NKEYS-1];
            line_s2_q <= line_s1_q;
            SERIAL_LINE_O <= ONE_WIRE_MODE_I ? line_s2_q : 1'b1;
            PLAY_START_O <= start_d;
            PLAY_STOP_O <= stop_d;
            PLAY_PAUSE_O <= pause_d;
            PLAY_PIECE_O <= piece_d;
            VOL_UP_O <= vup_d;
            VOL_DOWN_O <= vdn_d;
            BUSY_O <= (st_d != ST_IDLE);
        end
    end
endmodule

// ---- inc/btvc_consts.vh ----
// constants of the key trigger block
`ifndef BTVC_CONSTS_VH
`define BTVC_CONSTS_VH
`define BTVC_CLK_HZ 25000000
`define BTVC_DEBOUNCE_MS 10
`define BTVC_DEBOUNCE_CYC ((`BTVC_CLK_HZ / 1000) * `BTVC_DEBOUNCE_MS)
`define BTVC_WAY_W 4
`define BTVC_WAY_INVALID 4'h0
`define BTVC_WAY_EDGE_REP 4'h1
`define BTVC_WAY_EDGE_NOREP 4'h2
`define BTVC_WAY_LVL_LOOP 4'h3
`define BTVC_WAY_LVL_ONCE 4'h4
`define BTVC_WAY_LVL_NOMAINT 4'h5
`define BTVC_WAY_PLAY_STOP 4'h6
`define BTVC_WAY_NEXT_STOP 4'h7
`define BTVC_WAY_PREV_STOP 4'h8
`define BTVC_WAY_NEXT_WRAP 4'h9
`define BTVC_WAY_PREV_WRAP 4'ha
`define BTVC_WAY_PAUSE 4'hb
`define BTVC_WAY_STOP 4'hc
`define BTVC_WAY_VOL_UP 4'hd
`define BTVC_WAY_VOL_DOWN 4'he
`define BTVC_PIECE_W 8
`define BTVC_PIECE_RST 8'h00
`endif

// ---- verif/btvc_button_model.sv ----
// push button model: idle high, pressed low, with contact bounce
`timescale 1ns/10ps
module btvc_button_model (
    input wire clk_i,
    input wire [3:0] press_i,
    output logic [3:0] pin_o = 4'hf
);
    logic [3:0] d1_q = 4'h0;
    logic [3:0] d2_q = 4'h0;
    // ------------------------------------
    // contacts
    // ------------------------------------
    // one bounce cycle per change, shorter than the filter
    always @(posedge clk_i)
    begin
        d1_q <= press_i;
        d2_q <= d1_q;
        pin_o <= ~press_i ^ (d1_q ^ d2_q);
    end
endmodule

// ---- verif/btvc_kt_assertions.sv ----
// port checker for the key trigger block, bound to its top
`timescale 1ns/10ps
module btvc_kt_assertions #(
    parameter NKEYS = 4
) (
    input wire CLOCK_I,
    input wire RSTN_I,
    input wire [NKEYS-1:0] KEY_PIN_I,
    input wire ONE_WIRE_MODE_I,
    input wire PLAY_DONE_I,
    input wire SERIAL_LINE_O,
    input wire PLAY_START_O,
    input wire PLAY_STOP_O,
    input wire [7:0] PLAY_PIECE_O,
    input wire BUSY_O
);
    default clocking cb @(posedge CLOCK_I);
    endclocking
    default disable iff (!RSTN_I);
    // ------------------------------------
    // checks
    // ------------------------------------
    // margin of a few cycles covers the sync stages
    sequence s_ser_low;
        (ONE_WIRE_MODE_I && !KEY_PIN_I[NKEYS-1]) [*5];
    endsequence
    sequence s_ser_off;
        (!ONE_WIRE_MODE_I) [*3];
    endsequence
    a_ser_low: assert property (s_ser_low |-> !SERIAL_LINE_O)
        else $error("serial line not following key pin");
    a_ser_idle: assert property (s_ser_off |-> SERIAL_LINE_O)
        else $error("serial line not idle high");
    a_start_busy: assert property (PLAY_START_O |-> BUSY_O)
        else $error("start without busy");
    a_start_pulse: assert property (PLAY_START_O |=> !PLAY_START_O)
        else $error("start pulse too long");
    a_stop_pulse: assert property (PLAY_STOP_O |=> !PLAY_STOP_O)
        else $error("stop pulse too long");
    a_stop_idle: assert property (
        PLAY_STOP_O && !PLAY_START_O |=> !BUSY_O)
        else $error("busy kept after stop");
    a_busy_rise: assert property ($rose(BUSY_O) |-> PLAY_START_O)
        else $error("busy rose without start");
    a_busy_fall: assert property (
        $fell(BUSY_O) |-> $past(PLAY_DONE_I) || $past(PLAY_STOP_O)
        || PLAY_DONE_I || PLAY_STOP_O)
        else $error("busy fell without stop or end");
    a_piece_hold: assert property (
        $changed(PLAY_PIECE_O) |-> PLAY_START_O)
        else $error("piece changed without start");
endmodule
bind btvc_key_trigger btvc_kt_assertions #(.NKEYS(NKEYS)) u_chk (
    .CLOCK_I(CLOCK_I), .RSTN_I(RSTN_I), .KEY_PIN_I(KEY_PIN_I),
    .ONE_WIRE_MODE_I(ONE_WIRE_MODE_I), .PLAY_DONE_I(PLAY_DONE_I),
    .SERIAL_LINE_O(SERIAL_LINE_O), .PLAY_START_O(PLAY_START_O),
    .PLAY_STOP_O(PLAY_STOP_O), .PLAY_PIECE_O(PLAY_PIECE_O),
    .BUSY_O(BUSY_O));

// ---- verif/testbench.sv ----
// self-checking bench for the key trigger block
`timescale 1ns/10ps
module testbench;
    localparam logic [7:0] LAST = 8'hdb;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic owm = 1'b0;
    logic done = 1'b0;
    logic [3:0] press = 4'h0;
    logic [15:0] way = 16'h0;
    logic [31:0] piece = 32'h0;
    logic [31:0] seed = 32'h55;
    logic [3:0] pins;
    logic ser, st, sp, pa, vu, vd, busy;
    logic [7:0] pc;
    logic [7:0] p;
    logic [3:0] gw [6] = '{4'h7, 4'h7, 4'h9, 4'ha, 4'h9, 4'h8};
    logic [3:0] kw [8] = '{4'hb, 4'hb, 4'hc, 4'hc, 4'h0, 4'hf, 4'hd, 4'he};
    int fails = 0;
    int checked = 0;
    int est = 0, s = 0, nst = 0, nsp = 0, npa = 0, nv = 0;
    always #20 clk = ~clk;
    always @(posedge clk)
    begin
        nst <= nst + st;
        nsp <= nsp + sp;
        npa <= npa + pa;
        nv <= nv + vu + vd;
    end
    btvc_button_model btn (.clk_i(clk), .press_i(press), .pin_o(pins));
    // short filter keeps the run brief
    btvc_key_trigger #(.DEB_CYC(4)) dut (
        .CLOCK_I(clk), .RSTN_I(rstn), .KEY_PIN_I(pins), .KEY_WAY_I(way),
        .KEY_PIECE_I(piece), .ONE_WIRE_MODE_I(owm), .PLAY_DONE_I(done),
        .SERIAL_LINE_O(ser), .PLAY_START_O(st), .PLAY_STOP_O(sp),
        .PLAY_PAUSE_O(pa), .PLAY_PIECE_O(pc), .VOL_UP_O(vu),
        .VOL_DOWN_O(vd), .BUSY_O(busy));
    // ------------------------------------
    // helpers
    // ------------------------------------
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [7:0] step(logic [7:0] q, logic [3:0] w);
        case (w)
            4'h7: return (q == LAST) ? q : q + 8'h01;
            4'h8: return (q == 8'h00) ? q : q - 8'h01;
            4'h9: return (q == LAST) ? 8'h00 : q + 8'h01;
            default: return (q == 8'h00) ? LAST : q - 8'h01;
        endcase
    endfunction
    task automatic chk(logic [31:0] seen, logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            fails++;
            $display("[ERR] %0t got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic hold(int k, logic v);
        press[k] <= v;
        cyc(16);
    endtask
    task automatic hit(int k);
        hold(k, 1'b1);
        hold(k, 1'b0);
    endtask
    task automatic fin();
        done <= 1'b1;
        cyc(1);
        done <= 1'b0;
        cyc(2);
    endtask
    task automatic sw(int k, logic [3:0] w);
        way[4*k+:4] <= w;
        cyc(1);
    endtask
    task stop_test();
        if (fails == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        cyc(20000);
        fails++;
        stop_test();
    end
    initial
    begin
        cyc(4);
        rstn <= 1'b1;
        cyc(2);
        chk({ser, busy, pc}, 32'h200);
        piece[7:0] <= 8'(xs() % 32'hda);
        sw(0, 4'h1);
        press[0] <= 1'b1;
        cyc(2);
        hold(0, 1'b0);
        chk(nst, est);
        hit(0);
        hit(0);
        est += 2;
        chk(nst, est);
        chk(pc, piece[7:0]);
        fin();
        chk(busy, 0);
        sw(0, 4'h2);
        hit(0);
        hit(0);
        fin();
        hit(0);
        fin();
        est += 2;
        chk(nst, est);
        sw(0, 4'h3);
        hold(0, 1'b1);
        fin();
        s = nsp;
        hold(0, 1'b0);
        est += 2;
        chk(nst, est);
        chk({busy, 8'(nsp - s)}, 32'h1);
        sw(0, 4'h4);
        repeat (2)
        begin
            hold(0, 1'b1);
            fin();
            hold(0, 1'b1);
            hold(0, 1'b0);
        end
        est += 2;
        chk(nst, est);
        sw(0, 4'h5);
        hold(0, 1'b1);
        fin();
        hold(0, 1'b0);
        chk(busy, 1);
        fin();
        chk(busy, 0);
        est += 2;
        sw(0, 4'h6);
        s = nsp;
        hit(0);
        hit(0);
        chk({busy, 8'(nsp - s)}, 32'h1);
        piece[7:0] <= 8'hda;
        sw(0, 4'h1);
        hit(0);
        p = 8'hda;
        foreach (gw[i])
        begin
            sw(1, gw[i]);
            hit(1);
            p = step(p, gw[i]);
            chk(pc, p);
        end
        est += 8;
        chk(nst, est);
        s = nsp;
        foreach (kw[i])
        begin
            sw(1, kw[i]);
            hit(1);
        end
        chk({8'(npa), 8'(nsp - s), 8'(nv)}, 32'h020102);
        chk({busy, 8'(nst - est)}, 32'h0);
        sw(3, 4'h1);
        owm <= 1'b1;
        hold(3, 1'b1);
        chk(ser, 0);
        hold(3, 1'b0);
        chk({ser, busy}, 32'h2);
        sw(2, 4'h1);
        repeat (8)
        begin
            p = 8'(xs() % 32'hdc);
            piece[23:16] <= p;
            hit(2);
            chk(pc, p);
        end
        chk(nst - est, 8);
        // mid-run reset: outputs return to idle, keys still trigger
        rstn <= 1'b0;
        cyc(2);
        rstn <= 1'b1;
        cyc(2);
        chk({ser, busy, pc}, 32'h200);
        hit(2);
        chk({busy, pc}, {1'b1, p});
        stop_test();
    end
endmodule
